// File: rtl/dei_buf_if.sv
interface dei_buf_if #(parameter int W = 16);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport buffer (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// File: rtl/dei_defines.svh
`ifndef DEI_DEFINES_SVH
`define DEI_DEFINES_SVH

// Codes on the register select pins
`define DEI_FN_DATA 4'h0
`define DEI_FN_CTRL 4'h1
`define DEI_FN_PC 4'h2

`define DEI_DW 16
`define DEI_CTL_W 5
`define DEI_CTL_BYTE 0
`define DEI_CTL_DMA 1
`define DEI_CTL_RST 5'h00
`define DEI_PC_W 9
`define DEI_PC_RST 9'h000
`define DEI_PC_FIRST 9'h001
`define DEI_SER_BITS 16
`define DEI_OSC_DIV 4
`define DEI_BUF_DEPTH 2

`endif

// File: rtl/dei_fifo.sv
module dei_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 2
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  dei_buf_if.buffer bus
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int PW = AW + 1;

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic push, pop;

  always_comb begin
    bus.in_ready = (wp_q - rp_q) != PW'(DEPTH);
    bus.out_valid = wp_q != rp_q;
    bus.out_data = mem[rp_q[AW-1:0]];
    push = bus.in_valid & bus.in_ready;
    pop = bus.out_valid & bus.out_ready;
    wp_d = wp_q + PW'(push);
    rp_d = rp_q + PW'(pop);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (i_ce) begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // Storage carries no reset; only the pointers say what is valid
  always_ff @(posedge i_core_clk) begin
    if (i_ce && push) begin
      mem[wp_q[AW-1:0]] <= bus.in_data;
    end
  end
endmodule

// File: rtl/dei_pkg.sv
package dei_pkg;

  // Every pin from outside the core clock domain, synchronised as one vector
  typedef struct packed {
    logic cs_n;
    logic rw;
    logic strobe;
    logic [3:0] sel;
    logic [15:0] bus;
    logic ack;
    logic done_n;
    logic si_data;
    logic si_clk;
    logic si_gate;
    logic so_clk;
    logic so_gate;
    logic bit_pin;
    logic rst_pin_n;
    logic osc;
  } dei_pins_t;

  typedef enum logic [1:0] {
    SI_IDLE = 2'b00,
    SI_SHIFT = 2'b01,
    SI_FULL = 2'b11
  } dei_si_state_t;

endpackage

// File: rtl/dei_top.sv
// What this block does
// - Data bus released while chip select inactive
// - Byte or word mode from control and select
// - Strobe latches bus into selected register
// - Strobe fall after transfer raises event
// - Read/write high reads, low writes
// - Host pins honoured only with chip select
// - Select pins choose the internal register
// - DMA done low leaves DMA mode
// - Serial input shifts on clock falling edge
// - Input gate rise starts capture; completion event
// - Output gate high shifts out; fall event
// - Serial output released while gate low
// - Serial output changes at clock rise
// - Request asserted when DMA flag set
// - Request per accumulator exchange, cleared by acknowledge
// - Outside DMA, program drives request directly
// - Program sets bit pin; reads pin level
// - Reset zeroes counter, sets interrupt mask
// - After reset release execution starts at one
// - Internal clock is oscillator divided by four
// - Byte mode moves words as upper, lower
// - Output bit count equals clocks, sixteen max
// - Host counter load starts at address plus one
`include "dei_defines.svh"
module dei_top #(
  parameter int BUF_DEPTH = `DEI_BUF_DEPTH,
  parameter int SER_BITS = `DEI_SER_BITS
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_cs_n,
  input wire logic i_rw,
  input wire logic i_iface_strobe,
  input wire logic [3:0] i_reg_select,
  input wire logic [15:0] i_host_bus,
  output logic [15:0] o_host_bus,
  output logic o_host_bus_oe_n,
  input wire logic i_xfer_ack_in,
  input wire logic i_dma_done_in_n,
  output logic o_xfer_req_out,
  output logic o_xfer_req_out_oe_n,
  input wire logic i_ser_in_data,
  input wire logic i_ser_in_clk,
  input wire logic i_ser_in_gate,
  input wire logic i_ser_out_clk,
  input wire logic i_ser_out_gate,
  output logic o_ser_out_data,
  output logic o_ser_out_oe_n,
  input wire logic i_bit_pin,
  output logic o_bit_pin,
  output logic o_bit_pin_oe_n,
  input wire logic i_reset_n_in,
  input wire logic i_fundamental_clk,
  output logic o_sync_clk,
  output logic o_instr_tick,
  input wire logic i_prog_ctl_wr,
  input wire logic [4:0] i_prog_ctl,
  output logic [4:0] o_ctl,
  input wire logic i_or_wr,
  input wire logic [15:0] i_or_data,
  input wire logic i_acc_xchg,
  input wire logic i_prog_req_wr,
  input wire logic i_prog_req_val,
  input wire logic i_prog_bit_wr,
  input wire logic i_prog_bit_val,
  output logic o_bit_in,
  output logic o_ir_valid,
  output logic [15:0] o_ir_data,
  input wire logic i_ir_ready,
  output logic o_in_ready,
  output logic [15:0] o_sin_data,
  output logic o_sin_valid,
  input wire logic i_sin_take,
  input wire logic i_sout_load,
  input wire logic [15:0] i_sout_data,
  output logic o_host_xfer_ev,
  output logic o_sin_done_ev,
  output logic o_sout_done_ev,
  output logic [8:0] o_pc,
  output logic o_pc_start,
  output logic o_irq_mask,
  input wire logic i_mask_clr
);
  localparam int CNTW = $clog2(SER_BITS + 1);
  localparam int DVW = $clog2(`DEI_OSC_DIV);

  function automatic logic rose(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  function automatic logic fell(input logic cur, input logic prev);
    return prev & ~cur;
  endfunction

  // Pin synchronisers; stage 3 only remembers stage 2 for edge finding
  dei_pkg::dei_pins_t pin_raw, pin_s1_q, pin_s2_q, pin_s3_q, s, p;
  assign pin_raw = {i_cs_n, i_rw, i_iface_strobe, i_reg_select, i_host_bus, i_xfer_ack_in,
                    i_dma_done_in_n, i_ser_in_data, i_ser_in_clk, i_ser_in_gate,
                    i_ser_out_clk, i_ser_out_gate, i_bit_pin, i_reset_n_in,
                    i_fundamental_clk};
  assign s = pin_s2_q;
  assign p = pin_s3_q;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else if (i_ce) begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Host port, control register and program counter
  logic [4:0] ctl_q, ctl_d;
  logic wph_q, wph_d, rph_q, rph_d, mask_q, mask_d, start_q, start_d, xev_q, xev_d;
  logic [7:0] hi_q, hi_d;
  logic [8:0] pc_q, pc_d;
  logic [15:0] bus_q, bus_d, or_q;
  logic bus_oe_n_q, bus_oe_n_d, push;
  logic [15:0] push_data;
  logic xfer_end, core_rst, core_rel, byte_mode;

  assign xfer_end = ~s.cs_n & ~p.cs_n & fell(s.strobe, p.strobe);
  assign core_rst = ~s.rst_pin_n;
  assign core_rel = rose(s.rst_pin_n, p.rst_pin_n);
  assign byte_mode = ctl_q[`DEI_CTL_BYTE];

  always_comb begin
    ctl_d = ctl_q;
    wph_d = wph_q;
    rph_d = rph_q;
    hi_d = hi_q;
    pc_d = pc_q;
    mask_d = mask_q;
    start_d = 1'b0;
    xev_d = 1'b0;
    push = 1'b0;
    push_data = s.bus;
    if (i_prog_ctl_wr) begin
      ctl_d = i_prog_ctl;
    end
    if (i_mask_clr) begin
      mask_d = 1'b0;
    end
    if (xfer_end) begin
      xev_d = 1'b1;
      if (!s.rw) begin
        unique case (s.sel)
          `DEI_FN_DATA: begin
            if (byte_mode) begin
              wph_d = ~wph_q;
              if (wph_q) begin
                push = 1'b1;
                push_data = {hi_q, s.bus[7:0]};
              end else begin
                hi_d = s.bus[7:0];
              end
            end else begin
              push = 1'b1;
            end
          end
          `DEI_FN_CTRL: ctl_d = s.bus[4:0];
          `DEI_FN_PC: begin
            pc_d = {1'b0, s.bus[7:0]} + `DEI_PC_FIRST;
            start_d = 1'b1;
          end
          default: ;
        endcase
      end else if (s.sel == `DEI_FN_DATA && byte_mode) begin
        rph_d = ~rph_q;
      end
    end
    if (!ctl_d[`DEI_CTL_BYTE]) begin
      wph_d = 1'b0;
      rph_d = 1'b0;
    end
    if (!s.done_n) begin
      ctl_d[`DEI_CTL_DMA] = 1'b0;
    end
    if (core_rst) begin
      pc_d = `DEI_PC_RST;
      mask_d = 1'b1;
      start_d = 1'b0;
    end else if (core_rel) begin
      pc_d = `DEI_PC_FIRST;
      start_d = 1'b1;
    end
    bus_oe_n_d = ~(~s.cs_n & s.rw);
    unique case (s.sel)
      `DEI_FN_DATA: begin
        if (byte_mode) begin
          bus_d = rph_q ? {8'h00, or_q[7:0]} : {8'h00, or_q[15:8]};
        end else begin
          bus_d = or_q;
        end
      end
      `DEI_FN_CTRL: bus_d = {11'h000, ctl_q};
      `DEI_FN_PC: bus_d = {7'h00, pc_q};
      default: bus_d = 16'h0000;
    endcase
  end

  // Interrupt mask and counter; the rest keeps its contents over a core reset pulse
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl_q <= `DEI_CTL_RST;
      wph_q <= 1'b0;
      rph_q <= 1'b0;
      hi_q <= 8'h00;
      pc_q <= `DEI_PC_RST;
      mask_q <= 1'b1;
      start_q <= 1'b0;
      xev_q <= 1'b0;
      bus_q <= 16'h0000;
      bus_oe_n_q <= 1'b1;
    end else if (i_ce) begin
      ctl_q <= ctl_d;
      wph_q <= wph_d;
      rph_q <= rph_d;
      hi_q <= hi_d;
      pc_q <= pc_d;
      mask_q <= mask_d;
      start_q <= start_d;
      xev_q <= xev_d;
      bus_q <= bus_d;
      bus_oe_n_q <= bus_oe_n_d;
    end
  end

  // Output register is plain data, written only by the program
  always_ff @(posedge i_core_clk) begin
    if (i_ce && i_or_wr) begin
      or_q <= i_or_data;
    end
  end

  // Host words wait in a small buffer until the program takes them
  dei_buf_if #(.W(16)) ir_if ();
  logic ir_valid_q, popped_q, room_q;
  logic [15:0] ir_data_q;

  assign ir_if.in_valid = push;
  assign ir_if.in_data = push_data;
  // A take is ignored in the cycle after a pop, while o_ir_valid still lags
  assign ir_if.out_ready = i_ir_ready & ir_valid_q & ~popped_q;

  dei_fifo #(.W(16), .DEPTH(BUF_DEPTH)) u_ir_fifo (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .bus(ir_if.buffer)
  );

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ir_valid_q <= 1'b0;
      ir_data_q <= 16'h0000;
      popped_q <= 1'b0;
      room_q <= 1'b0;
    end else if (i_ce) begin
      ir_valid_q <= ir_if.out_valid & ~(ir_if.out_ready);
      ir_data_q <= ir_if.out_data;
      popped_q <= ir_if.out_ready;
      room_q <= ir_if.in_ready & ~push;
    end
  end

  // DMA request and bit pin; open-drain pins pull low while enable is low
  logic req_q, req_d, dma_prev_q, bit_q, bit_d, bit_in_q;

  always_comb begin
    req_d = req_q;
    if (ctl_q[`DEI_CTL_DMA]) begin
      if (rose(s.ack, p.ack)) begin
        req_d = 1'b0;
      end
      if (!dma_prev_q || i_acc_xchg) begin
        req_d = 1'b1;
      end
    end else if (i_prog_req_wr) begin
      req_d = i_prog_req_val;
    end
    bit_d = i_prog_bit_wr ? i_prog_bit_val : bit_q;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_q <= 1'b0;
      dma_prev_q <= 1'b0;
      bit_q <= 1'b1;
      bit_in_q <= 1'b0;
    end else if (i_ce) begin
      req_q <= req_d;
      dma_prev_q <= ctl_q[`DEI_CTL_DMA];
      bit_q <= bit_d;
      bit_in_q <= s.bit_pin;
    end
  end

  // Serial input capture
  dei_pkg::dei_si_state_t si_st_q, si_st_d;
  logic [15:0] si_sr_q, si_sr_d;
  logic [CNTW-1:0] si_cnt_q, si_cnt_d;
  logic si_ev_q, si_ev_d;

  always_comb begin
    si_st_d = si_st_q;
    si_sr_d = si_sr_q;
    si_cnt_d = si_cnt_q;
    si_ev_d = 1'b0;
    unique case (si_st_q)
      dei_pkg::SI_IDLE: begin
        if (rose(s.si_gate, p.si_gate)) begin
          si_st_d = dei_pkg::SI_SHIFT;
          si_cnt_d = '0;
        end
      end
      dei_pkg::SI_SHIFT: begin
        if (s.si_gate && fell(s.si_clk, p.si_clk)) begin
          si_sr_d = {si_sr_q[14:0], s.si_data};
          si_cnt_d = si_cnt_q + CNTW'(1);
          if (si_cnt_q == CNTW'(SER_BITS - 1)) begin
            si_st_d = dei_pkg::SI_FULL;
            si_ev_d = 1'b1;
          end
        end else if (!s.si_gate) begin
          si_st_d = (si_cnt_q != '0) ? dei_pkg::SI_FULL : dei_pkg::SI_IDLE;
          si_ev_d = si_cnt_q != '0;
        end
      end
      dei_pkg::SI_FULL: begin
        if (i_sin_take) begin
          si_st_d = dei_pkg::SI_IDLE;
          si_sr_d = 16'h0000;
        end
      end
      default: si_st_d = dei_pkg::SI_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      si_st_q <= dei_pkg::SI_IDLE;
      si_sr_q <= 16'h0000;
      si_cnt_q <= '0;
      si_ev_q <= 1'b0;
    end else if (i_ce) begin
      si_st_q <= si_st_d;
      si_sr_q <= si_sr_d;
      si_cnt_q <= si_cnt_d;
      si_ev_q <= si_ev_d;
    end
  end

  // Serial output; clocks beyond the register length shift out zeros
  logic [15:0] so_sr_q, so_sr_d;
  logic [CNTW-1:0] so_cnt_q, so_cnt_d;
  logic so_out_q, so_out_d, so_ev_q, so_ev_d;

  always_comb begin
    so_sr_d = so_sr_q;
    so_cnt_d = so_cnt_q;
    so_out_d = so_out_q;
    so_ev_d = 1'b0;
    if (i_sout_load) begin
      so_sr_d = i_sout_data;
      so_cnt_d = '0;
    end else if (s.so_gate && rose(s.so_clk, p.so_clk)) begin
      if (so_cnt_q != CNTW'(SER_BITS)) begin
        so_out_d = so_sr_q[15];
        so_sr_d = {so_sr_q[14:0], 1'b0};
        so_cnt_d = so_cnt_q + CNTW'(1);
      end else begin
        so_out_d = 1'b0;
      end
    end else if (fell(s.so_gate, p.so_gate) && so_cnt_q != '0) begin
      so_ev_d = 1'b1;
      so_sr_d = 16'h0000;
      so_cnt_d = '0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      so_sr_q <= 16'h0000;
      so_cnt_q <= '0;
      so_out_q <= 1'b0;
      so_ev_q <= 1'b0;
    end else if (i_ce) begin
      so_sr_q <= so_sr_d;
      so_cnt_q <= so_cnt_d;
      so_out_q <= so_out_d;
      so_ev_q <= so_ev_d;
    end
  end

  // Internal clock: one period per four oscillator rising edges
  logic [DVW-1:0] div_q, div_d;
  logic sync_q, tick_q, tick_d, so_oe_n_q;

  always_comb begin
    div_d = div_q;
    tick_d = 1'b0;
    if (rose(s.osc, p.osc)) begin
      div_d = div_q + DVW'(1);
      tick_d = div_q == DVW'(`DEI_OSC_DIV - 1);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= '0;
      sync_q <= 1'b0;
      tick_q <= 1'b0;
      so_oe_n_q <= 1'b1;
    end else if (i_ce) begin
      div_q <= div_d;
      sync_q <= div_d[DVW-1];
      tick_q <= tick_d;
      so_oe_n_q <= ~s.so_gate;
    end
  end

  assign o_host_bus = bus_q;
  assign o_host_bus_oe_n = bus_oe_n_q;
  assign o_xfer_req_out = req_q;
  assign o_xfer_req_out_oe_n = req_q;
  assign o_ser_out_data = so_out_q;
  assign o_ser_out_oe_n = so_oe_n_q;
  assign o_bit_pin = bit_q;
  assign o_bit_pin_oe_n = bit_q;
  assign o_sync_clk = sync_q;
  assign o_instr_tick = tick_q;
  assign o_ctl = ctl_q;
  assign o_bit_in = bit_in_q;
  assign o_ir_valid = ir_valid_q;
  assign o_ir_data = ir_data_q;
  assign o_in_ready = room_q;
  assign o_sin_data = si_sr_q;
  assign o_sin_valid = si_st_q[1]; // Set only in the full state, so it stays a plain flop bit
  assign o_host_xfer_ev = xev_q;
  assign o_sin_done_ev = si_ev_q;
  assign o_sout_done_ev = so_ev_q;
  assign o_pc = pc_q;
  assign o_pc_start = start_q;
  assign o_irq_mask = mask_q;
endmodule

// File: tb/dei_peer.sv
module dei_peer (
  input wire logic i_req_line,
  input wire logic i_so_data,
  output logic o_ack,
  output logic o_si_data,
  output logic o_si_clk,
  output logic o_si_gate,
  output logic o_so_clk,
  output logic o_so_gate,
  output logic [15:0] o_so_word
);
  timeunit 1ns;
  timeprecision 1ps;
  int ack_delay = 20;
  initial begin
    {o_ack, o_si_data, o_si_gate, o_so_clk, o_so_gate, o_so_word} = '0;
    o_si_clk = 1'b1;
  end
  // Ack is held until the request drops, as a real controller would
  always begin
    wait (i_req_line === 1'b1);
    // Odd offsets keep every pin change off the core clock edge
    #(ack_delay + 1);
    o_ack = 1'b1;
    wait (i_req_line === 1'b0);
    #9;
    o_ack = 1'b0;
  end
  task automatic send_si(input logic [15:0] w);
    #1;
    o_si_gate = 1'b1;
    #32;
    for (int i = 15; i >= 0; i--) begin
      o_si_data = w[i];
      #32;
      o_si_clk = 1'b0;
      #32;
      o_si_clk = 1'b1;
    end
    o_si_data = ~o_si_data;
    #32;
    o_si_gate = 1'b0;
  endtask
  task automatic take_so(input int n);
    #1;
    o_so_gate = 1'b1;
    #32;
    for (int i = 0; i < n; i++) begin
      o_so_clk = 1'b1;
      #32;
      o_so_word = {o_so_word[14:0], i_so_data};
      o_so_clk = 1'b0;
      #32;
    end
    o_so_gate = 1'b0;
  endtask
endmodule

// File: tb/dei_top_monitor.sv
module dei_top_monitor (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_rw,
  input wire logic o_host_bus_oe_n,
  input wire logic i_ser_out_gate,
  input wire logic o_ser_out_oe_n,
  input wire logic [4:0] o_ctl,
  input wire logic i_acc_xchg,
  input wire logic i_dma_done_in_n,
  input wire logic i_xfer_ack_in,
  input wire logic i_prog_ctl_wr,
  input wire logic i_prog_req_wr,
  input wire logic o_xfer_req_out,
  input wire logic i_reset_n_in,
  input wire logic [8:0] o_pc,
  input wire logic o_pc_start,
  input wire logic o_irq_mask,
  input wire logic o_instr_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking
    @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  property p_bus_own;
    !o_host_bus_oe_n |-> $past(!i_cs_n && i_rw, 3);
  endproperty
  a_bus_own: assert property (p_bus_own) else $error("host bus driven outside a read");
  property p_so_own;
    !o_ser_out_oe_n |-> $past(i_ser_out_gate, 3);
  endproperty
  a_so_own: assert property (p_so_own) else $error("serial out driven with gate low");
  property p_dma_set;
    $rose(o_ctl[1]) |=> o_xfer_req_out;
  endproperty
  a_dma_set: assert property (p_dma_set) else $error("request not raised by dma flag");
  property p_xchg;
    o_ctl[1] && i_acc_xchg && i_dma_done_in_n |=> o_xfer_req_out;
  endproperty
  a_xchg: assert property (p_xchg) else $error("exchange did not raise request");
  property p_ack_clr;
    o_ctl[1] && $rose(i_xfer_ack_in) ##0 (!i_acc_xchg && !i_prog_ctl_wr && !i_prog_req_wr) [*5]
      |-> !o_xfer_req_out;
  endproperty
  a_ack_clr: assert property (p_ack_clr) else $error("request held after ack");
  property p_pin_rst;
    !i_reset_n_in [*4] |-> o_pc == 9'h000 && o_irq_mask;
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset state wrong");
  property p_start_one;
    $rose(i_reset_n_in) |-> ##[2:5] (o_pc_start && o_pc == 9'h001);
  endproperty
  a_start_one: assert property (p_start_one) else $error("start address not one");
  property p_tick;
    o_instr_tick |=> !o_instr_tick [*8];
  endproperty
  a_tick: assert property (p_tick) else $error("internal clock ticks too close");
  c_read: cover property (!o_host_bus_oe_n);
  c_ack: cover property ($rose(i_xfer_ack_in) && o_xfer_req_out);
  c_start: cover property (o_pc_start);
endmodule

bind dei_top dei_top_monitor u_mon (.*);

// File: tb/dei_top_tb.sv
module dei_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk, i_rst_n, i_ce, i_cs_n, i_rw, i_iface_strobe, i_xfer_ack_in;
  logic i_dma_done_in_n, i_ser_in_data, i_ser_in_clk, i_ser_in_gate, i_ser_out_clk;
  logic i_ser_out_gate, i_bit_pin, i_reset_n_in, i_fundamental_clk, i_prog_ctl_wr;
  logic i_or_wr, i_acc_xchg, i_prog_req_wr, i_prog_req_val, i_prog_bit_wr, i_prog_bit_val;
  logic i_ir_ready, i_sin_take, i_sout_load, i_mask_clr, ext_bit, rd_oe_n;
  logic o_host_bus_oe_n, o_xfer_req_out, o_xfer_req_out_oe_n, o_ser_out_data;
  logic o_ser_out_oe_n, o_bit_pin, o_bit_pin_oe_n, o_sync_clk, o_instr_tick, o_bit_in;
  logic o_ir_valid, o_in_ready, o_sin_valid, o_host_xfer_ev, o_sin_done_ev;
  logic o_sout_done_ev, o_pc_start, o_irq_mask;
  logic [3:0] i_reg_select;
  logic [4:0] i_prog_ctl, o_ctl;
  logic [8:0] o_pc;
  logic [15:0] i_host_bus, o_host_bus, i_or_data, i_sout_data, o_ir_data, o_sin_data;
  logic [15:0] host_drv, rd_word, so_word;
  int num_errors = 0, samples_checked = 0, n_host = 0, n_sout = 0, n_sin = 0, n_tick = 0;
  int n_osc = 0, n_sync = 0, k0;
  // Open-drain bit pin: pulled up unless either side pulls low
  assign i_bit_pin = o_bit_pin_oe_n ? ext_bit : 1'b0;
  assign i_host_bus = !o_host_bus_oe_n ? o_host_bus : host_drv;
  dei_top dut_u (.*);
  dei_peer u_peer (.i_req_line(o_xfer_req_out_oe_n), .i_so_data(o_ser_out_data),
    .o_ack(i_xfer_ack_in), .o_si_data(i_ser_in_data), .o_si_clk(i_ser_in_clk),
    .o_si_gate(i_ser_in_gate), .o_so_clk(i_ser_out_clk), .o_so_gate(i_ser_out_gate),
    .o_so_word(so_word));
  always #2 i_core_clk = ~i_core_clk;
  always #31.25 i_fundamental_clk = ~i_fundamental_clk;
  always @(posedge i_core_clk) begin
    n_host <= n_host + int'(o_host_xfer_ev);
    n_sout <= n_sout + int'(o_sout_done_ev);
    n_sin <= n_sin + int'(o_sin_done_ev);
    n_tick <= n_tick + int'(o_instr_tick);
  end
  always @(posedge i_fundamental_clk) n_osc++;
  always @(posedge o_sync_clk) n_sync++;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      num_errors++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic host(input logic cs_n, input logic rw, input logic [3:0] sel,
                      input logic [15:0] d);
    i_cs_n <= cs_n;
    i_rw <= rw;
    i_reg_select <= sel;
    host_drv <= d;
    cyc(4);
    i_iface_strobe <= 1'b1;
    cyc(3);
    rd_word = o_host_bus;
    rd_oe_n = o_host_bus_oe_n;
    i_iface_strobe <= 1'b0;
    cyc(6);
    i_cs_n <= 1'b1;
    i_rw <= 1'b0;
    host_drv <= ~d;
    cyc(5);
  endtask
  task automatic pop(input logic [15:0] e);
    chk("ir_data", e, o_ir_data);
    i_ir_ready <= 1'b1;
    cyc(1);
    i_ir_ready <= 1'b0;
    cyc(2);
  endtask
  task automatic req_is(input logic v);
    for (int k = 0; k < 400 && o_xfer_req_out !== v; k++)
      cyc(1);
    chk("req", v, o_xfer_req_out);
    if (o_xfer_req_out !== v)
      stop_test();
  endtask
  task automatic prog_ctl(input logic [4:0] v);
    i_prog_ctl <= v;
    i_prog_ctl_wr <= 1'b1;
    cyc(1);
    i_prog_ctl_wr <= 1'b0;
  endtask
  task automatic prog_bit(input logic v, input logic ext, input logic e);
    i_prog_bit_val <= v;
    i_prog_bit_wr <= 1'b1;
    ext_bit <= ext;
    cyc(1);
    i_prog_bit_wr <= 1'b0;
    cyc(5);
    chk("bit_in", e, o_bit_in);
  endtask
  task automatic pulse_xchg();
    i_acc_xchg <= 1'b1;
    cyc(1);
    i_acc_xchg <= 1'b0;
  endtask
  initial begin
    {i_core_clk, i_rst_n, i_rw, i_iface_strobe, i_fundamental_clk, i_prog_ctl_wr, i_or_wr,
     i_acc_xchg, i_prog_req_wr, i_prog_req_val, i_prog_bit_wr, i_prog_bit_val, i_ir_ready,
     i_sin_take, i_sout_load, i_mask_clr, i_reg_select, i_prog_ctl, i_or_data,
     i_sout_data, host_drv} = '0;
    {i_ce, i_cs_n, i_dma_done_in_n, i_reset_n_in, ext_bit} = '1;
    cyc(3);
    i_rst_n <= 1'b1;
    cyc(8);
    chk("pc", 16'h0001, o_pc);
    chk("mask", 16'h0001, o_irq_mask);
    host(1'b1, 1'b0, 4'h0, 16'h7777);
    chk("ir_valid", 16'h0000, o_ir_valid);
    host(1'b0, 1'b0, 4'h0, 16'h1234);
    chk("oe_n", 16'h0001, rd_oe_n);
    host(1'b0, 1'b0, 4'h0, 16'hBEEF);
    chk("host_ev", 16'h0002, 16'(n_host));
    chk("in_ready", 16'h0000, o_in_ready);
    host(1'b0, 1'b0, 4'h0, 16'h5555);
    pop(16'h1234);
    pop(16'hBEEF);
    chk("ir_valid", 16'h0000, o_ir_valid);
    host(1'b0, 1'b0, 4'h1, 16'h0001);
    chk("ctl", 16'h0001, o_ctl);
    i_or_data <= 16'hA55A;
    i_or_wr <= 1'b1;
    cyc(1);
    i_or_wr <= 1'b0;
    host(1'b0, 1'b1, 4'h0, 16'h0000);
    chk("oe_n", 16'h0000, rd_oe_n);
    chk("rd_hi", 16'h00A5, {8'h00, rd_word[7:0]});
    host(1'b0, 1'b1, 4'h0, 16'h0000);
    chk("rd_lo", 16'h005A, {8'h00, rd_word[7:0]});
    chk("oe_n", 16'h0001, o_host_bus_oe_n);
    host(1'b0, 1'b0, 4'h1, 16'h0000);
    host(1'b0, 1'b0, 4'h2, 16'h0010);
    chk("pc", 16'h0011, o_pc);
    prog_ctl(5'h02);
    req_is(1'b1);
    req_is(1'b0);
    u_peer.ack_delay = 600;
    pulse_xchg();
    req_is(1'b1);
    cyc(40);
    chk("req", 16'h0001, o_xfer_req_out);
    req_is(1'b0);
    i_dma_done_in_n <= 1'b0;
    cyc(6);
    i_dma_done_in_n <= 1'b1;
    chk("ctl", 16'h0000, o_ctl);
    i_prog_req_val <= 1'b1;
    i_prog_req_wr <= 1'b1;
    cyc(1);
    i_prog_req_wr <= 1'b0;
    cyc(2);
    chk("req", 16'h0001, o_xfer_req_out);
    i_prog_req_val <= 1'b0;
    i_prog_req_wr <= 1'b1;
    cyc(1);
    i_prog_req_wr <= 1'b0;
    req_is(1'b0);
    u_peer.send_si(16'hC3A5);
    cyc(6);
    chk("sin", 16'hC3A5, o_sin_data);
    chk("sin_v", 16'h0001, o_sin_valid);
    chk("sin_ev", 16'h0001, 16'(n_sin));
    i_sin_take <= 1'b1;
    cyc(1);
    i_sin_take <= 1'b0;
    cyc(3);
    chk("sin", 16'h0000, o_sin_data);
    chk("sin_v", 16'h0000, o_sin_valid);
    chk("so_oe", 16'h0001, o_ser_out_oe_n);
    i_sout_data <= 16'h9A3C;
    i_sout_load <= 1'b1;
    cyc(1);
    i_sout_load <= 1'b0;
    u_peer.take_so(16);
    cyc(6);
    chk("so_word", 16'h9A3C, so_word);
    chk("sout_ev", 16'h0001, 16'(n_sout));
    prog_bit(1'b0, 1'b1, 1'b0);
    prog_bit(1'b1, 1'b0, 1'b0);
    prog_bit(1'b1, 1'b1, 1'b1);
    prog_ctl(5'h01);
    i_mask_clr <= 1'b1;
    cyc(1);
    i_mask_clr <= 1'b0;
    cyc(2);
    chk("mask", 16'h0000, o_irq_mask);
    i_reset_n_in <= 1'b0;
    cyc(260);
    chk("pc", 16'h0000, o_pc);
    chk("mask", 16'h0001, o_irq_mask);
    chk("ctl", 16'h0001, o_ctl);
    i_reset_n_in <= 1'b1;
    cyc(6);
    chk("pc", 16'h0001, o_pc);
    // Wait for an oscillator rise, then let it clear the synchroniser
    k0 = n_osc;
    for (int k = 0; k < 20 && n_osc == k0; k++)
      cyc(1);
    if (n_osc == k0) begin
      $display("mismatch osc_edge expected 1 seen 0");
      num_errors++;
    end
    cyc(6);
    chk("tick", 16'(n_osc / 4), 16'(n_tick));
    chk("sync_clk", 16'((n_osc + 2) / 4), 16'(n_sync));
    stop_test();
  end
endmodule
